/* src/freq_meas_pair.sv */
// Function
// [R1] Low-frequency mode counts reference ticks across one measured-signal period.
// [R2] Reference is 80 MHz, 20 MHz, 100 kHz internal, or an external known source.
// [R3] Pairs are fixed: lead counter feeds only its own partner counter.
// [R4] High-frequency mode counts measured edges across a known-width gate pulse.
// [R5] Large-range lead emits one pulse lasting N measured-signal periods.
// [R6] Lead pulse gates partner, which counts reference ticks into J.
// [R7] Averaging sampled mode counts T1 measured and T2 reference ticks per window.
// [R8] Averaging between sample clocks is enabled out of reset.
// [R9] Without averaging, each sample reports only the last complete period.
// [R10] User keeps measured signal at least twice the sample clock rate.
// [R11] Sampled window spans exactly one sample clock period, reference counted.
// [R12] Pulse-width mode counts while gate active, stores on fall, then ignores.
// [R13] Overrun flagged when no complete period lies between two sample clocks.
// [R14] Only raw tick counts are returned; host converts to frequency.
// [R15] Every captured count is emitted in capture order.
`timescale 1ns/100ps
module freq_meas_pair
  import freq_meas_pkg::*;
(
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    arst_n,
  input  wire logic    clock_en,
  // Asynchronous terminals
  input  wire logic    measured_frequency,
  input  wire logic    programmable_function_terminal,
  input  wire logic    sample_clock,
  input  wire logic    ext_reference,
  // Control
  input  wire logic    arm,
  input  wire logic    stop,
  input  wire cfg_t    cfg_in,
  // Results and status
  output logic         result_valid,
  output result_t      result,
  output logic         busy,
  output logic         overrun,
  output logic         lead_pulse
);

  state_t              st;
  state_t              next_st;
  logic [NUM_PINS-1:0] pins;
  logic                meas_edge;
  logic                sample_edge;
  logic                ref_tick;
  logic                gate_level;
  logic                lead_src;
  logic                part_src;
  logic                uses_lead;
  logic [COUNT_W-1:0]  ref_inc;
  logic [COUNT_W-1:0]  meas_inc;

  assign pins[PIN_MEAS]   = measured_frequency;
  assign pins[PIN_GATE]   = programmable_function_terminal;
  assign pins[PIN_SAMPLE] = sample_clock;
  assign pins[PIN_EXT]    = ext_reference;

  assign meas_edge   = st.sync2[PIN_MEAS] & ~st.prev[PIN_MEAS];
  assign sample_edge = st.sync2[PIN_SAMPLE] & ~st.prev[PIN_SAMPLE];
  assign ref_inc     = COUNT_W'(ref_tick);
  assign meas_inc    = COUNT_W'(meas_edge);

  always_comb begin
    unique case (st.cfg.ref_sel)
      REF_80M:  ref_tick = st.tick[0]; // [R2]
      REF_20M:  ref_tick = st.tick[1]; // [R2]
      REF_100K: ref_tick = st.tick[2]; // [R2]
      REF_EXTERNAL: ref_tick = st.sync2[PIN_EXT] & ~st.prev[PIN_EXT]; // [R2]
    endcase
  end

  // Partner gate: own terminal, or the lead counter of this pair only
  assign gate_level = (st.cfg.mode == MODE_PULSE_WIDTH ||
                       (st.cfg.mode == MODE_HIGH_FREQ && st.cfg.gate_from_terminal))
                      ? st.sync2[PIN_GATE] : st.lead_out; // [R3] [R4] [R6]
  assign lead_src  = (st.cfg.mode == MODE_LARGE_RANGE) ? meas_edge : ref_tick; // [R5]
  assign part_src  = (st.cfg.mode == MODE_HIGH_FREQ) ? meas_edge : ref_tick; // [R4]
  assign uses_lead = cfg_in.mode == MODE_LARGE_RANGE ||
                     (cfg_in.mode == MODE_HIGH_FREQ && !cfg_in.gate_from_terminal);

  always_comb begin
    next_st              = st;
    next_st.result_valid = 1'b0;
    next_st.sync1        = pins;
    next_st.sync2        = st.sync1;
    next_st.prev         = st.sync2;
    next_st.gate_prev    = gate_level;
    // Fractional accumulators keep the exact average rate of each timebase
    for (int i = 0; i < NUM_TB; i++) begin
      if (st.acc[i] >= ACC_MOD - TB_INC[i]) begin
        next_st.acc[i]  = st.acc[i] - (ACC_MOD - TB_INC[i]);
        next_st.tick[i] = 1'b1; // [R2]
      end else begin
        next_st.acc[i]  = st.acc[i] + TB_INC[i];
        next_st.tick[i] = 1'b0;
      end
    end
    // Period tracking for the non-averaged sample and overrun check
    if (st.cfg.mode == MODE_SAMPLED && st.pst != ST_IDLE) begin
      next_st.per_cnt = st.per_cnt + ref_inc;
      if (meas_edge) begin
        if (st.seen_edge) begin
          next_st.last_per    = st.per_cnt + ref_inc; // [R9]
          next_st.period_done = 1'b1; // [R13]
        end
        next_st.seen_edge = 1'b1;
        next_st.per_cnt   = '0;
      end
    end
    if (stop) begin
      next_st.pst      = ST_IDLE;
      next_st.lst      = LEAD_IDLE;
      next_st.lead_out = 1'b0;
    end else if (arm && (st.pst == ST_IDLE || st.pst == ST_DONE)) begin
      next_st.cfg         = cfg_in;
      next_st.pst         = ST_ARMED;
      next_st.lst         = uses_lead ? LEAD_WAIT : LEAD_IDLE;
      next_st.lead_out    = 1'b0;
      next_st.overrun     = 1'b0;
      next_st.seen_edge   = 1'b0;
      next_st.period_done = 1'b0;
      next_st.per_cnt     = '0;
      // Old gate source must not look like a fresh rise after arm
      next_st.gate_prev   = 1'b1; // [R12]
    end else begin
      // Lead counter of the pair
      unique case (st.lst)
        LEAD_WAIT: begin
          if (lead_src) begin
            next_st.lst      = LEAD_HIGH;
            next_st.lead_out = 1'b1; // [R5]
            next_st.lead_cnt = '0;
          end
        end
        LEAD_HIGH: begin
          if (lead_src) begin
            next_st.lead_cnt = st.lead_cnt + 1'b1;
            if (st.lead_cnt + 1'b1 >= st.cfg.divide_n) begin
              next_st.lst      = LEAD_DONE;
              next_st.lead_out = 1'b0; // [R5]
            end
          end
        end
        LEAD_IDLE, LEAD_DONE: ;
      endcase
      // Partner counter
      unique case (st.pst)
        ST_ARMED: begin
          if (st.cfg.mode == MODE_SAMPLED) begin
            if (sample_edge) begin
              next_st.pst          = ST_COUNT; // [R11]
              next_st.cnt_primary  = '0;
              next_st.cnt_embedded = '0;
              next_st.period_done  = 1'b0;
            end
          end else if (st.cfg.mode == MODE_LOW_FREQ) begin
            if (meas_edge) begin
              next_st.pst         = ST_COUNT; // [R1]
              next_st.cnt_primary = '0;
            end
          end else if (gate_level && !st.gate_prev) begin
            // Armed mid-pulse waits for the next active edge
            next_st.pst         = ST_COUNT; // [R12]
            next_st.cnt_primary = '0;
          end
        end
        ST_COUNT: begin
          if (st.cfg.mode == MODE_SAMPLED) begin
            next_st.cnt_primary  = st.cnt_primary + ref_inc; // [R7] [R11]
            next_st.cnt_embedded = st.cnt_embedded + meas_inc; // [R7]
            if (sample_edge) begin
              next_st.result_valid     = 1'b1; // [R15]
              next_st.result.mode      = st.cfg.mode;
              next_st.result.overrun   = !next_st.period_done; // [R13]
              if (st.cfg.average_between_sample_clocks) begin
                next_st.result.primary  = st.cnt_primary + ref_inc; // [R7] [R14]
                next_st.result.embedded = st.cnt_embedded + meas_inc; // [R7]
              end else begin
                next_st.result.primary  = next_st.last_per; // [R9]
                next_st.result.embedded = COUNT_W'(1);
              end
              if (!next_st.period_done) begin
                next_st.overrun = 1'b1; // [R13]
              end
              next_st.cnt_primary  = '0; // [R11]
              next_st.cnt_embedded = '0;
              next_st.period_done  = 1'b0;
            end
          end else if (st.cfg.mode == MODE_LOW_FREQ) begin
            next_st.cnt_primary = st.cnt_primary + ref_inc; // [R1]
            if (meas_edge) begin
              next_st.pst             = ST_DONE;
              next_st.result_valid    = 1'b1; // [R15]
              next_st.result.primary  = st.cnt_primary + ref_inc; // [R1] [R14]
              next_st.result.embedded = COUNT_W'(1);
              next_st.result.mode     = st.cfg.mode;
              next_st.result.overrun  = 1'b0;
            end
          end else if (!gate_level) begin
            // Stored once; later gate and source edges are ignored
            next_st.pst             = ST_DONE; // [R12]
            next_st.result_valid    = 1'b1; // [R15]
            next_st.result.primary  = st.cnt_primary; // [R6] [R14]
            next_st.result.embedded = (st.cfg.mode == MODE_LARGE_RANGE)
                                      ? st.cfg.divide_n : '0;
            next_st.result.mode     = st.cfg.mode;
            next_st.result.overrun  = 1'b0;
          end else begin
            next_st.cnt_primary = st.cnt_primary + COUNT_W'(part_src); // [R4] [R6] [R12]
          end
        end
        ST_IDLE, ST_DONE: ;
      endcase
    end
    next_st.busy = next_st.pst == ST_ARMED || next_st.pst == ST_COUNT;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st     <= state_t'(0);
      st.cfg <= CFG_RESET; // [R8]
    end else if (clock_en) begin
      st <= next_st;
    end
  end

  assign result_valid = st.result_valid;
  assign result       = st.result;
  assign busy         = st.busy;
  assign overrun      = st.overrun;
  assign lead_pulse   = st.lead_out;

  // Checks
  logic armed_once;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      armed_once <= 1'b0;
    end else if (clock_en && arm) begin
      armed_once <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_lead_rise_armed;
    st.cfg.mode == MODE_LARGE_RANGE && st.pst == ST_ARMED && $rose(st.lead_out)
      && clock_en && !arm && !stop;
  endsequence

  sequence s_partner_counting;
    st.pst == ST_COUNT;
  endsequence

  chk_avg_default: assert property ( // [R8]
    !armed_once |-> st.cfg.average_between_sample_clocks)
    else $error("averaging not enabled out of reset");

  chk_lead_width: assert property ( // [R5]
    $fell(st.lead_out) && st.cfg.divide_n != '0 && !$past(stop) && !$past(arm)
      |-> st.lead_cnt == st.cfg.divide_n)
    else $error("lead pulse width differs from N periods");

  chk_partner_gate: assert property ( // [R6]
    s_lead_rise_armed |=> s_partner_counting)
    else $error("partner did not start on lead pulse");

  chk_low_freq_end: assert property ( // [R1]
    st.cfg.mode == MODE_LOW_FREQ && st.pst == ST_COUNT && meas_edge && clock_en
      && !stop && !arm |=> result_valid && st.pst == ST_DONE)
    else $error("period end not captured");

  chk_high_count: assert property ( // [R4]
    st.cfg.mode == MODE_HIGH_FREQ && st.pst == ST_COUNT && gate_level && meas_edge
      && clock_en && !stop && !arm |=> st.cnt_primary == $past(st.cnt_primary) + 1)
    else $error("measured edge not counted during gate");

  chk_embedded_count: assert property ( // [R7]
    st.cfg.mode == MODE_SAMPLED && st.pst == ST_COUNT && meas_edge && !sample_edge
      && clock_en && !stop && !arm |=> st.cnt_embedded == $past(st.cnt_embedded) + 1)
    else $error("embedded count missed a measured edge");

  chk_sample_window: assert property ( // [R11]
    st.cfg.mode == MODE_SAMPLED && st.pst == ST_COUNT && sample_edge && clock_en
      && !stop && !arm |=> result_valid && st.cnt_primary == '0)
    else $error("window not closed at sample clock");

  chk_single_hold: assert property ( // [R12]
    st.pst == ST_DONE && clock_en && !arm && !stop |=> st.pst == ST_DONE && !result_valid)
    else $error("single measurement reacted after storing");

  chk_non_avg: assert property ( // [R9]
    result_valid && st.result.mode == MODE_SAMPLED && !st.cfg.average_between_sample_clocks
      |-> st.result.embedded == 1 && st.result.primary == st.last_per)
    else $error("non-averaged sample not last period");

  chk_overrun_flag: assert property ( // [R13]
    result_valid && st.result.overrun |-> overrun)
    else $error("overrun not flagged");

endmodule // freq_meas_pair

/* src/freq_meas_pkg.sv */
package freq_meas_pkg;

  // Timebase synthesis: rates in kHz, fractional accumulator modulo the core rate
  localparam int CLOCK_KHZ   = 250000;
  localparam int TB_FAST_KHZ = 80000;
  localparam int TB_MID_KHZ  = 20000;
  localparam int TB_SLOW_KHZ = 100;
  localparam int NUM_TB      = 3;
  localparam int ACC_W       = 18;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLOCK_KHZ);
  localparam logic [NUM_TB-1:0][ACC_W-1:0] TB_INC =
    {ACC_W'(TB_SLOW_KHZ), ACC_W'(TB_MID_KHZ), ACC_W'(TB_FAST_KHZ)};

  localparam int COUNT_W = 32;

  // Terminal positions in the synchroniser vectors
  localparam int PIN_MEAS   = 0;
  localparam int PIN_GATE   = 1;
  localparam int PIN_SAMPLE = 2;
  localparam int PIN_EXT    = 3;
  localparam int NUM_PINS   = 4;

  typedef enum logic [2:0] {
    MODE_LOW_FREQ, MODE_HIGH_FREQ, MODE_LARGE_RANGE, MODE_SAMPLED, MODE_PULSE_WIDTH
  } mode_t;

  typedef enum logic [1:0] {REF_80M, REF_20M, REF_100K, REF_EXTERNAL} ref_sel_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT, ST_DONE} part_state_t;

  typedef enum logic [1:0] {LEAD_IDLE, LEAD_WAIT, LEAD_HIGH, LEAD_DONE} lead_state_t;

  typedef struct packed {
    mode_t                        mode;
    ref_sel_t                     ref_sel;
    logic                         gate_from_terminal;
    logic                         average_between_sample_clocks;
    logic [COUNT_W-1:0]           divide_n;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{mode: MODE_LOW_FREQ, ref_sel: REF_80M,
    gate_from_terminal: 1'b0, average_between_sample_clocks: 1'b1, divide_n: '0};

  typedef struct packed {
    logic [COUNT_W-1:0]           primary;
    logic [COUNT_W-1:0]           embedded;
    mode_t                        mode;
    logic                         overrun;
  } result_t;

  typedef struct packed {
    logic [NUM_PINS-1:0]          sync1;
    logic [NUM_PINS-1:0]          sync2;
    logic [NUM_PINS-1:0]          prev;
    logic [NUM_TB-1:0][ACC_W-1:0] acc;
    logic [NUM_TB-1:0]            tick;
    cfg_t                         cfg;
    part_state_t                  pst;
    lead_state_t                  lst;
    logic                         lead_out;
    logic [COUNT_W-1:0]           lead_cnt;
    logic                         gate_prev;
    logic [COUNT_W-1:0]           cnt_primary;
    logic [COUNT_W-1:0]           cnt_embedded;
    logic [COUNT_W-1:0]           per_cnt;
    logic [COUNT_W-1:0]           last_per;
    logic                         seen_edge;
    logic                         period_done;
    result_t                      result;
    logic                         result_valid;
    logic                         overrun;
    logic                         busy;
  } state_t;

endpackage

/* tb/freq_sources.sv */
`timescale 1ns/100ps
module freq_sources (
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Half periods in core cycles, zero holds the line low
  input  var  int   meas_half,
  input  var  int   samp_half,
  input  var  int   ext_half,
  // Terminals
  output logic      meas,
  output logic      samp,
  output logic      extref
);
  int cyc;

  function automatic logic wave(int c, int h);
    return (h != 0) && ((c % (2 * h)) < h);
  endfunction

  // One shared count keeps every source phase locked, so ratios are exact
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cyc    <= 0;
      meas   <= 1'b0;
      samp   <= 1'b0;
      extref <= 1'b0;
    end else begin
      cyc    <= cyc + 1;
      meas   <= wave(cyc, meas_half);
      samp   <= wave(cyc, samp_half);
      extref <= wave(cyc, ext_half);
    end
  end
endmodule // freq_sources

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import freq_meas_pkg::*;
  typedef struct {result_t r; int tol;} note_t;

  logic        clock, arst_n, pgate, arm, stop;
  logic        clock_en;
  cfg_t        cfg_in;
  int          meas_half, samp_half, ext_half;
  logic        meas, samp, extref;
  logic        result_valid, busy, overrun, lead_pulse;
  result_t     result;
  note_t       notes[$];
  note_t       got;
  int          error_cnt, checks_done, cycles, lead_len;
  logic [31:0] rng;
  int          rates[3] = '{TB_FAST_KHZ, TB_MID_KHZ, TB_SLOW_KHZ};

  freq_sources src (.clock(clock), .arst_n(arst_n), .meas_half(meas_half),
    .samp_half(samp_half), .ext_half(ext_half), .meas(meas), .samp(samp), .extref(extref));

  freq_meas_pair uut (.clock(clock), .arst_n(arst_n), .clock_en(clock_en),
    .measured_frequency(meas), .programmable_function_terminal(pgate),
    .sample_clock(samp), .ext_reference(extref), .arm(arm), .stop(stop),
    .cfg_in(cfg_in), .result_valid(result_valid), .result(result), .busy(busy),
    .overrun(overrun), .lead_pulse(lead_pulse));

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic near(logic [31:0] seen, int exp, int tol, string what);
    check(32'(((seen + 32'(tol) >= 32'(exp)) && (seen <= 32'(exp + tol))) === 1'b1),
      32'h1, what);
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Settle time lets the sources run clean after a rate change
  task automatic start(mode_t m, ref_sel_t rs, logic gt, logic avg, int n);
    repeat (80) @(posedge clock);
    cfg_in <= '{mode: m, ref_sel: rs, gate_from_terminal: gt,
               average_between_sample_clocks: avg, divide_n: 32'(n)};
    arm    <= 1'b1;
    @(posedge clock);
    arm    <= 1'b0;
  endtask

  task automatic expect_res(mode_t m, int p, int e, logic ov, int tol);
    note_t n;
    n.r   = '{primary: 32'(p), embedded: 32'(e), mode: m, overrun: ov};
    n.tol = tol;
    notes.push_back(n);
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 5000 && notes.size() > 0; k++) @(posedge clock);
    check(32'(notes.size()), 32'h0, "results missing");
  endtask

  task automatic halt();
    stop <= 1'b1;
    @(posedge clock);
    stop <= 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (lead_pulse === 1'b1) lead_len++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
    if (result_valid === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0, "unexpected result");
      end else begin
        got = notes.pop_front();
        check(32'(result.mode), 32'(got.r.mode), "mode");
        check(32'(result.overrun), 32'(got.r.overrun), "overrun bit");
        if (got.tol >= 0) begin
          near(result.primary, got.r.primary, got.tol, "primary");
          near(result.embedded, got.r.embedded, got.tol, "embedded");
        end
      end
    end
  end

  initial begin
    int m, k;
    arst_n = 1'b0; arm = 1'b0; stop = 1'b0; pgate = 1'b0; cfg_in = CFG_RESET;
    meas_half = 0; samp_half = 20; ext_half = 2; rng = 32'hA37A4F09;
    clock_en = 1'b1;
    repeat (16) @(posedge clock);
    check(32'({result_valid, busy, overrun, lead_pulse}), 32'h0, "reset outputs");
    arst_n <= 1'b1;
    // Random periods against an aligned external reference give exact counts
    for (k = 0; k < 4; k++) begin
      m = 4 * (2 + int'(xorshift() % 8));
      meas_half <= m / 2;
      expect_res(MODE_LOW_FREQ, m / 4, 1, 1'b0, 0);
      start(MODE_LOW_FREQ, REF_EXTERNAL, 1'b0, 1'b1, 0);
      #1 check(32'(busy), 32'h1, "busy after arm");
      @(posedge clock);
      arm <= 1'b1;
      @(posedge clock);
      arm <= 1'b0;
      drain();
    end
    meas_half <= 125;
    for (k = 0; k < 3; k++) begin
      expect_res(MODE_LOW_FREQ, 250 * rates[k] / 250000, 1, 1'b0, 1);
      start(MODE_LOW_FREQ, ref_sel_t'(k), 1'b0, 1'b1, 0);
      drain();
    end
    meas_half <= 1;
    expect_res(MODE_HIGH_FREQ, 10, 0, 1'b0, 1);
    start(MODE_HIGH_FREQ, REF_EXTERNAL, 1'b0, 1'b1, 5);
    drain();
    expect_res(MODE_HIGH_FREQ, 15, 0, 1'b0, 1);
    start(MODE_HIGH_FREQ, REF_EXTERNAL, 1'b1, 1'b1, 5);
    pgate <= 1'b1;
    repeat (30) @(posedge clock);
    pgate <= 1'b0;
    drain();
    meas_half <= 6;
    lead_len = 0;
    expect_res(MODE_LARGE_RANGE, 12, 4, 1'b0, 1);
    start(MODE_LARGE_RANGE, REF_EXTERNAL, 1'b0, 1'b1, 4);
    drain();
    near(32'(lead_len), 48, 1, "lead pulse width");
    meas_half <= 4;
    for (k = 0; k < 3; k++) expect_res(MODE_SAMPLED, 13, 5, 1'b0, 1);
    start(MODE_SAMPLED, REF_80M, 1'b0, 1'b1, 0);
    drain();
    halt();
    for (k = 0; k < 2; k++) expect_res(MODE_SAMPLED, 2, 1, 1'b0, 0);
    start(MODE_SAMPLED, REF_EXTERNAL, 1'b0, 1'b0, 0);
    drain();
    halt();
    meas_half <= 0;
    for (k = 0; k < 2; k++) expect_res(MODE_SAMPLED, 13, 0, 1'b1, 1);
    start(MODE_SAMPLED, REF_80M, 1'b0, 1'b1, 0);
    drain();
    halt();
    check(32'(overrun), 32'h1, "overrun sticky");
    // Armed with the gate already high: only the next full pulse counts
    pgate <= 1'b1;
    expect_res(MODE_PULSE_WIDTH, 5, 0, 1'b0, 1);
    start(MODE_PULSE_WIDTH, REF_EXTERNAL, 1'b0, 1'b1, 0);
    #1 check(32'(overrun), 32'h0, "overrun cleared by arm");
    repeat (10) @(posedge clock);
    pgate <= 1'b0;
    repeat (10) @(posedge clock);
    pgate <= 1'b1;
    repeat (20) @(posedge clock);
    pgate <= 1'b0;
    drain();
    repeat (10) @(posedge clock);
    pgate <= 1'b1;
    repeat (20) @(posedge clock);
    pgate <= 1'b0;
    repeat (40) @(posedge clock);
    // Frozen core must not take an arm
    clock_en <= 1'b0;
    arm      <= 1'b1;
    repeat (4) @(posedge clock);
    arm      <= 1'b0;
    clock_en <= 1'b1;
    @(posedge clock);
    #1 check(32'(busy), 32'h0, "arm taken while frozen");
    give_verdict();
  end
endmodule // tb_top
